// File: verilog/io_seq_pkg.sv
package io_seq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_POR     = 7'h01,
    ST_INIT    = 7'h02,
    ST_CONFIG  = 7'h04,
    ST_RELGSR  = 7'h08,
    ST_RELGTS  = 7'h10,
    ST_GWEWAIT = 7'h20,
    ST_USER    = 7'h40
  } seq_state_e;

  // Idle pad termination encodings
  localparam logic [1:0] TERM_PULLDOWN = 2'h0;
  localparam logic [1:0] TERM_PULLUP   = 2'h1;
  localparam logic [1:0] TERM_FLOAT    = 2'h2;

  // Timing counts in startup clock cycles
  localparam int          INIT_CYCLES_DEFAULT = 16;
  localparam logic [15:0] INIT_CYCLES         = 16'h0010;
  localparam int          CNT_W               = 16;
  localparam logic [15:0] GWE_DELAY_DEFAULT   = 16'h0001;
  localparam int          MODE_W              = 3;

  // AXI4-Lite register offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_GWEDLY = 8'h08;
  localparam int         CTRL_TERM_LSB  = 0;
  localparam int         CTRL_START_BIT = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: verilog/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2
  #(parameter int W = 1)
  (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
  );

  logic [W-1:0] meta;

  // Two-stage synchroniser; first stage read only by second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule
`default_nettype wire

// File: verilog/step_counter.sv
`timescale 1ns/1ps
`default_nettype none
module step_counter
  (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        load,
    input  wire logic [15:0] load_value,
    output logic             expired
  );

  logic [15:0] count;
  logic [15:0] next_count;

  // Down counter; expired while zero
  always_comb
  begin
    next_count = count;
    if (load)
      next_count = load_value;
    else if (count != 16'h0000)
      next_count = count - 16'h0001;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= 16'h0000;
    else
      count <= next_count;
  end

  assign expired = (count == 16'h0000);

endmodule
`default_nettype wire

// File: verilog/io_powerup_config_sequencer.sv
// Notes on behaviour
// - Hold power-on reset until core, auxiliary and bank-2 supplies are good.
// - Pad drivers stay high impedance from power-on through configuration.
// - Strap low enables user-pad pull-ups until configuration completes.
// - Strap high leaves pull-ups off, pads float.
// - Strap pin has a weak internal pull-up; open reads high.
// - Start configuration memory initialisation once power is valid.
// - Global set-reset asserted during initialisation, clearing pad storage low.
// - Raise init-done and sample three mode bits; outside holds them stable.
// - Release global set-reset at end of configuration; polarity may be inverted.
// - Release global three-state in startup, entering user operation.
// - After three-state release, used pads active, unused pads pulled down by default.
// - Unused pad termination selectable: pull-up, pull-down or floating.
// - Release global write enable one cycle after three-state by default.
// - In user mode strap pull-ups revert to user settings; strap becomes I/O.
`timescale 1ns/1ps
`default_nettype none
module io_powerup_config_sequencer
  import io_seq_pkg::*;
  #(
    parameter logic [15:0] GWE_DELAY = GWE_DELAY_DEFAULT
  )
  (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Supplies good and pins (asynchronous)
    input  wire logic        core_supply_ok,
    input  wire logic        auxiliary_supply_ok,
    input  wire logic        bank_output_supply_ok,
    input  wire logic        pullup_strap_pin_in,
    input  wire logic        mode_select_bit0,
    input  wire logic        mode_select_bit1,
    input  wire logic        mode_select_bit2,
    input  wire logic        config_load_done,
    // Loaded design's per-storage polarity choice
    input  wire logic        storage_set_reset_invert,
    // User pull-up setting for the strap pad in user mode
    input  wire logic        user_strap_pullup,
    // Pad control outputs
    output logic             power_on_reset,
    output logic             global_set_reset_net,
    output logic             global_tristate_net,
    output logic             global_write_gate_net,
    output logic             pad_pullup_en,
    output logic             pad_pulldown_en,
    output logic             idle_pad_pullup_en,
    output logic             idle_pad_pulldown_en,
    output logic             strap_pad_pullup_en,
    output logic             strap_pad_is_gpio,
    output logic             storage_reset_level,
    output logic             init_done,
    output logic [2:0]       config_mode,
    output logic             user_mode,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
  );

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [7:0] pins_raw;
  logic [7:0] pins_sync;
  logic       supplies_good;
  logic       strap_level;
  logic [2:0] mode_pins;
  logic       load_done;

  // Strap pad has a weak pull-up: the pad model resolves an open pin high
  // weak strap pull-up
  assign strap_pad_pullup_en = user_mode ? user_strap_pullup : 1'b1;

  // Strap enters inverted, so the synchroniser's cleared state reads as an open, high strap
  assign pins_raw = {config_load_done, mode_select_bit2, mode_select_bit1, mode_select_bit0,
                     ~pullup_strap_pin_in, bank_output_supply_ok, auxiliary_supply_ok, core_supply_ok};

  sync2 #(.W(8)) u_pin_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (pins_raw),
    .q       (pins_sync)
  );

  assign supplies_good = pins_sync[0] & pins_sync[1] & pins_sync[2];
  assign strap_level   = ~pins_sync[3];
  assign mode_pins     = pins_sync[6:4];
  assign load_done     = pins_sync[7];

  //////////////////////////////////////////////////////////////////////////////
  // Software registers

  logic [1:0]  term_sel;
  logic [1:0]  next_term_sel;
  logic        sw_start;
  logic        next_sw_start;
  logic [15:0] gwe_delay;
  logic [15:0] next_gwe_delay;

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  seq_state_e  state;
  seq_state_e  next_state;
  logic        strap_low;
  logic        next_strap_low;
  logic [2:0]  next_config_mode;
  logic        cnt_load;
  logic [15:0] cnt_value;
  logic        cnt_expired;

  step_counter u_step
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .load       (cnt_load),
    .load_value (cnt_value),
    .expired    (cnt_expired)
  );

  // Next state; configuration waits for the load source and software start
  always_comb
  begin
    next_state       = state;
    next_strap_low   = strap_low;
    next_config_mode = config_mode;
    cnt_load         = 1'b0;
    cnt_value        = INIT_CYCLES;
    case (state)
      ST_POR:
      begin
        // strap followed from power-on; last sample kept at exit
        next_strap_low = ~strap_level;
        if (supplies_good)
        begin
          next_state     = ST_INIT;
          cnt_load       = 1'b1;
          cnt_value      = INIT_CYCLES;
        end
      end
      ST_INIT:
      begin
        if (cnt_expired)
        begin
          next_state       = ST_CONFIG;
          next_config_mode = mode_pins;
        end
      end
      ST_CONFIG:
        if (load_done && sw_start)
          next_state = ST_RELGSR;
      ST_RELGSR:
        next_state = ST_RELGTS;
      ST_RELGTS:
      begin
        next_state = ST_GWEWAIT;
        cnt_load   = 1'b1;
        cnt_value  = (gwe_delay == 16'h0000) ? 16'h0000 : gwe_delay - 16'h0001;
      end
      ST_GWEWAIT:
        if (cnt_expired)
          next_state = ST_USER;
      ST_USER:
        next_state = ST_USER;
      default:
        next_state = ST_POR;
    endcase
    // Supply loss restarts the whole sequence
    if (!supplies_good)
      next_state = ST_POR;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state       <= ST_POR;
      strap_low   <= 1'b0;
      config_mode <= 3'h0;
    end
    else
    begin
      state       <= next_state;
      strap_low   <= next_strap_low;
      config_mode <= next_config_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Global nets and pad controls, registered

  logic next_por;
  logic next_gsr;
  logic next_gts;
  logic next_gwe;
  logic next_pu;
  logic next_ipu;
  logic next_ipd;
  logic next_user;
  logic next_init_done;
  logic active_next;

  always_comb
  begin
    active_next    = (next_state == ST_GWEWAIT) || (next_state == ST_USER);
    next_por       = (next_state == ST_POR);
    // set-reset held through init and config
    next_gsr       = (next_state == ST_POR) || (next_state == ST_INIT) || (next_state == ST_CONFIG);
    next_gts       = ~active_next;
    next_gwe       = (next_state == ST_USER);
    next_pu        = ~active_next && next_strap_low;
    next_ipu       = active_next ? (term_sel == TERM_PULLUP) : next_pu;
    next_ipd       = active_next && (term_sel == TERM_PULLDOWN);
    next_user      = (next_state == ST_USER);
    next_init_done = ~((next_state == ST_POR) || (next_state == ST_INIT));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      power_on_reset        <= 1'b1;
      global_set_reset_net  <= 1'b1;
      global_tristate_net   <= 1'b1;
      global_write_gate_net <= 1'b0;
      pad_pullup_en         <= 1'b0;
      idle_pad_pullup_en    <= 1'b0;
      idle_pad_pulldown_en  <= 1'b0;
      user_mode             <= 1'b0;
      init_done             <= 1'b0;
    end
    else
    begin
      power_on_reset        <= next_por;
      global_set_reset_net  <= next_gsr;
      global_tristate_net   <= next_gts;
      global_write_gate_net <= next_gwe;
      pad_pullup_en         <= next_pu;
      idle_pad_pullup_en    <= next_ipu;
      idle_pad_pulldown_en  <= next_ipd;
      user_mode             <= next_user;
      init_done             <= next_init_done;
    end
  end

  // Used pads never pulled down by the sequencer
  assign pad_pulldown_en   = 1'b0;
  assign strap_pad_is_gpio = user_mode;
  // pad storage cleared low while set-reset is asserted
  // after release the loaded polarity decides the level
  assign storage_reset_level = global_set_reset_net ? 1'b0 : storage_set_reset_invert;

  //////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one transfer each way, answer one cycle after both taken

  logic        aw_held;
  logic        next_aw_held;
  logic [7:0]  aw_addr;
  logic [7:0]  next_aw_addr;
  logic        w_held;
  logic        next_w_held;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0]  w_strb;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb
  begin
    next_aw_held   = aw_held;
    next_aw_addr   = aw_addr;
    next_w_held    = w_held;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = s_axi_bvalid;
    next_bresp     = s_axi_bresp;
    next_rvalid    = s_axi_rvalid;
    next_rdata     = s_axi_rdata;
    next_rresp     = s_axi_rresp;
    next_term_sel  = term_sel;
    next_sw_start  = sw_start;
    next_gwe_delay = gwe_delay;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        REG_CTRL:
        begin
          if (w_strb[0])
          begin
            next_term_sel = w_data[CTRL_TERM_LSB +: 2];
            next_sw_start = w_data[CTRL_START_BIT];
          end
        end
        REG_GWEDLY:
        begin
          if (w_strb[0])
            next_gwe_delay[7:0] = w_data[7:0];
          if (w_strb[1])
            next_gwe_delay[15:8] = w_data[15:8];
        end
        REG_STATUS:
          next_bresp = RESP_OKAY;
        default:
          next_bresp = RESP_SLVERR;
      endcase
    end
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL:   next_rdata = {29'h0, sw_start, term_sel};
        REG_STATUS: next_rdata = {19'h0, state, config_mode, strap_low, user_mode, init_done};
        REG_GWEDLY: next_rdata = {16'h0, gwe_delay};
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
      term_sel     <= TERM_PULLDOWN;
      sw_start     <= 1'b1;
      gwe_delay    <= GWE_DELAY;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      term_sel     <= next_term_sel;
      sw_start     <= next_sw_start;
      gwe_delay    <= next_gwe_delay;
    end
  end

endmodule
`default_nettype wire

// File: test/io_seq_sva.sv
`timescale 1ns/1ps
`default_nettype none
module io_seq_sva
  (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       core_supply_ok,
    input wire logic       pullup_strap_pin_in,
    input wire logic       mode_select_bit0,
    input wire logic       mode_select_bit1,
    input wire logic       mode_select_bit2,
    input wire logic       storage_set_reset_invert,
    input wire logic       user_strap_pullup,
    input wire logic       power_on_reset,
    input wire logic       global_set_reset_net,
    input wire logic       global_tristate_net,
    input wire logic       global_write_gate_net,
    input wire logic       pad_pullup_en,
    input wire logic       strap_pad_pullup_en,
    input wire logic       strap_pad_is_gpio,
    input wire logic       storage_reset_level,
    input wire logic       init_done,
    input wire logic [2:0] config_mode,
    input wire logic       user_mode
  );
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Release steps: three-state drops two cycles after set-reset
  sequence gts_drop_s;
    global_tristate_net ##1 global_tristate_net ##1 !global_tristate_net;
  endsequence
  sequence gwe_late_s;
    !global_write_gate_net ##[1:8] $rose(global_write_gate_net);
  endsequence
  a_por_supply_loss: assert property (!core_supply_ok |-> ##[1:4] power_on_reset)
    else $error("reset not raised on supply loss");
  a_por_exit_good: assert property ($fell(power_on_reset) |-> $past(core_supply_ok, 2))
    else $error("reset left without good supply");
  a_pads_hiz: assert property (global_set_reset_net |-> global_tristate_net)
    else $error("pads driven during configuration");
  a_init_gsr: assert property (!init_done |-> global_set_reset_net && !global_write_gate_net)
    else $error("set-reset or write gate wrong in init");
  a_strap_pullup: assert property (init_done && global_set_reset_net |-> pad_pullup_en == !pullup_strap_pin_in)
    else $error("pull-up does not follow strap");
  a_mode_held: assert property (init_done |-> config_mode == {mode_select_bit2, mode_select_bit1, mode_select_bit0})
    else $error("mode not sampled");
  a_gsr_then_gts: assert property ($fell(global_set_reset_net) |-> gts_drop_s)
    else $error("three-state not released after set-reset");
  a_gwe_after_gts: assert property ($fell(global_tristate_net) |-> gwe_late_s)
    else $error("write gate not released after three-state");
  a_strap_user: assert property (strap_pad_is_gpio == user_mode && strap_pad_pullup_en == (user_mode ? user_strap_pullup : 1'b1))
    else $error("strap pad not handed over");
  a_storage_level: assert property (storage_reset_level == (global_set_reset_net ? 1'b0 : storage_set_reset_invert))
    else $error("storage reset level wrong");
endmodule
bind io_powerup_config_sequencer io_seq_sva i_io_seq_sva (.aclk, .aresetn, .core_supply_ok, .pullup_strap_pin_in,
  .mode_select_bit0, .mode_select_bit1, .mode_select_bit2, .storage_set_reset_invert, .user_strap_pullup,
  .power_on_reset, .global_set_reset_net, .global_tristate_net, .global_write_gate_net, .pad_pullup_en,
  .strap_pad_pullup_en, .strap_pad_is_gpio, .storage_reset_level, .init_done, .config_mode, .user_mode);
`default_nettype wire

// File: test/board_model.sv
`timescale 1ns/1ps
`default_nettype none
module board_model
  (
    input  wire logic       aclk,
    input  wire logic       power_on,
    input  wire logic [1:0] strap_sel,
    input  wire logic [2:0] mode_val,
    input  wire logic [8:0] sup_dly,
    input  wire logic       init_done,
    output logic            core_supply_ok,
    output logic            auxiliary_supply_ok,
    output logic            bank_output_supply_ok,
    output logic            pullup_strap_pin_in,
    output logic            mode_select_bit0,
    output logic            mode_select_bit1,
    output logic            mode_select_bit2,
    output logic            config_load_done
  );
  logic [7:0] ramp;
  logic [7:0] load;
  // Cycle counters since power and since init done
  always_ff @(posedge aclk)
  begin
    ramp <= !power_on ? 8'h00 : ramp + {7'h0, ramp != 8'hff};
    load <= !(power_on && init_done) ? 8'h00 : load + {7'h0, load != 8'hff};
  end
  // Supplies rise in any order; all drop together on power loss
  always_comb
  begin
    core_supply_ok = power_on && ramp > {5'h0, sup_dly[2:0]};
    auxiliary_supply_ok = power_on && ramp > {5'h0, sup_dly[5:3]};
    bank_output_supply_ok = power_on && ramp > {5'h0, sup_dly[8:6]};
    config_load_done = load > 8'h04;
  end
  assign pullup_strap_pin_in = strap_sel != 2'h0;
  assign {mode_select_bit2, mode_select_bit1, mode_select_bit0} = mode_val;
endmodule
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import io_seq_pkg::*;
  logic        aclk, aresetn, power_on, user_strap_pullup, storage_set_reset_invert;
  logic [1:0]  strap_sel;
  logic [2:0]  mode_val;
  logic [8:0]  sup_dly;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        core_supply_ok, auxiliary_supply_ok, bank_output_supply_ok, pullup_strap_pin_in, config_load_done;
  logic        mode_select_bit0, mode_select_bit1, mode_select_bit2, power_on_reset, global_set_reset_net;
  logic        global_tristate_net, global_write_gate_net, pad_pullup_en, pad_pulldown_en, idle_pad_pullup_en;
  logic        idle_pad_pulldown_en, strap_pad_pullup_en, strap_pad_is_gpio, storage_reset_level, init_done, user_mode;
  logic [2:0]  config_mode;
  int          errors, cmp_count, seed;
  io_powerup_config_sequencer i_io_powerup_config_sequencer (.aclk, .aresetn, .core_supply_ok, .auxiliary_supply_ok,
    .bank_output_supply_ok, .pullup_strap_pin_in, .mode_select_bit0, .mode_select_bit1, .mode_select_bit2,
    .config_load_done, .storage_set_reset_invert, .user_strap_pullup, .power_on_reset, .global_set_reset_net,
    .global_tristate_net, .global_write_gate_net, .pad_pullup_en, .pad_pulldown_en, .idle_pad_pullup_en,
    .idle_pad_pulldown_en, .strap_pad_pullup_en, .strap_pad_is_gpio, .storage_reset_level, .init_done,
    .config_mode, .user_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  board_model i_board_model (.aclk, .power_on, .strap_sel, .mode_val, .sup_dly, .init_done, .core_supply_ok,
    .auxiliary_supply_ok, .bank_output_supply_ok, .pullup_strap_pin_in, .mode_select_bit0, .mode_select_bit1,
    .mode_select_bit2, .config_load_done);
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // Selects the output a wait is watching
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = power_on_reset;
      1: pick = init_done;
      2: pick = global_tristate_net;
      3: pick = global_write_gate_net;
      default: pick = user_mode;
    endcase
  endfunction
  // Counts edges until the level shows; a hang ends the run
  task automatic wait_for(input int sel, input logic lvl, output int n);
    n = 0;
    while (pick(sel) !== lvl && n < 300)
    begin
      @(posedge aclk);
      #1;
      n++;
    end
    if (n >= 300)
    begin
      errors++;
      $display("ERROR %0t wait timed out", $time);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50)
      check(n, 0, "write timeout");
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50)
      check(n, 0, "read timeout");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // One power-up from reset to user mode, then a supply loss
  task automatic run_seq(input logic [1:0] st, input logic [1:0] term, input logic [15:0] dly);
    int n;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge aclk);
    aresetn <= 1'b0;
    power_on <= 1'b0;
    strap_sel <= st;
    mode_val <= 3'($random(seed));
    sup_dly <= 9'($random(seed));
    user_strap_pullup <= 1'($random(seed));
    storage_set_reset_invert <= 1'($random(seed));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(REG_CTRL, d, r);
    check(d, 32'h4, "ctrl reset");
    axi_read(REG_GWEDLY, d, r);
    check(d, {16'h0, GWE_DELAY_DEFAULT}, "delay reset");
    axi_read(8'h0c, d, r);
    check({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped read");
    // Strap high run holds start low to prove the sequencer waits
    axi_write(REG_CTRL, {29'h0, st != 2'h1, term}, r);
    axi_write(REG_GWEDLY, {16'h0, dly}, r);
    check(r, RESP_OKAY, "delay write");
    power_on <= 1'b1;
    wait_for(0, 1'b0, n);
    wait_for(1, 1'b1, n);
    check(n, INIT_CYCLES_DEFAULT + 1, "init length");
    check({config_mode, pad_pullup_en, global_tristate_net, global_set_reset_net, global_write_gate_net},
      {mode_val, st == 2'h0, 3'b110}, "config phase");
    if (st == 2'h1)
    begin
      repeat (40) @(posedge aclk);
      #1;
      check(global_set_reset_net, 1'b1, "start held");
      axi_write(REG_CTRL, {29'h1, term}, r);
    end
    wait_for(2, 1'b0, n);
    check(global_set_reset_net, 1'b0, "set-reset first");
    wait_for(3, 1'b1, n);
    check(n, (dly == 16'h0) ? 1 : dly, "write gate delay");
    wait_for(4, 1'b1, n);
    check({idle_pad_pullup_en, idle_pad_pulldown_en, pad_pulldown_en, pad_pullup_en, strap_pad_is_gpio,
      storage_reset_level}, {term == 2'h1, term == 2'h0, 3'b001, storage_set_reset_invert}, "user pads");
    axi_read(REG_STATUS, d, r);
    check(d[5:0], {mode_val, st == 2'h0, 2'b11}, "status");
    @(posedge aclk);
    power_on <= 1'b0;
    wait_for(0, 1'b1, n);
    @(posedge aclk);
    #1;
    check({global_tristate_net, global_write_gate_net}, 2'b10, "supply loss");
    $display("test strap %0d term %0d delay %0d done", st, term, dly);
  endtask
  initial
  begin
    seed = 80330;
    errors = 0;
    cmp_count = 0;
    {aresetn, power_on, user_strap_pullup, storage_set_reset_invert, strap_sel, mode_val, sup_dly} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    // Strap low, high and open, paired with pull-down, pull-up and floating termination
    run_seq(2'h0, TERM_PULLDOWN, 16'h0001);
    run_seq(2'h1, TERM_PULLUP, 16'h0003);
    run_seq(2'h2, TERM_FLOAT, 16'h0000);
    final_report();
  end
endmodule
`default_nettype wire
